// *** core/supply_supervisor_cfg.svh ***
// Timing figures and reset values of the supply supervisor gating logic.
// Assumes a 10 MHz clock; included by the timer and gating design modules.
`ifndef SUPPLY_SUPERVISOR_CFG_SVH
`define SUPPLY_SUPERVISOR_CFG_SVH
`define CLK_PERIOD_NS      100
`define GRACE_TIME_NS      10000
`define GRACE_CYCLES       (`GRACE_TIME_NS / `CLK_PERIOD_NS)
`define HOLD_TIME_MS       200
`define HOLD_CYCLES_DEF    (`HOLD_TIME_MS * 1000000 / `CLK_PERIOD_NS)
`define CNT_W              24
`define GRACE_W            8
`define CNT_ZERO           24'h000000
`define GRACE_ZERO         8'h00
`endif

// *** core/supply_supervisor_pkg.sv ***
// Types shared by the supply supervisor gating modules.
// Assumes the constants header is available on the include path.
package supply_supervisor_pkg;
    typedef enum logic [1:0] {
        GATE_PASS,
        GATE_GRACE,
        GATE_BLOCK
    } gate_state_t;
endpackage : supply_supervisor_pkg

// *** core/hold_timer.sv ***
// Reset-hold timer: counts the hold period, flags first and second half.
// Assumes a synchronous restart input and a clock at the configured rate.
`timescale 1ns/10ps
`include "supply_supervisor_cfg.svh"
module hold_timer #(
    parameter logic [`CNT_W-1:0] HOLD_CYCLES = `CNT_W'(`HOLD_CYCLES_DEF)
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic srst,
    // Control
    input  wire logic restart,
    // Status
    output logic      running,
    output logic      firstHalf
);
    logic [`CNT_W-1:0] count_q;
    logic [`CNT_W-1:0] halfCycles;
    logic              done;

    // Half point and end of period
    assign halfCycles = HOLD_CYCLES >> 1;
    assign done       = (count_q >= HOLD_CYCLES);
    assign running    = restart || !done;
    assign firstHalf  = restart || (count_q < halfCycles);

    // Held at zero while restarted, count up from zero while below the period
    always_ff @(posedge clock) begin
        if (srst || restart) begin
            count_q <= `CNT_ZERO;
        end else if (!done) begin
            count_q <= count_q + `CNT_W'(1);
        end
    end
endmodule : hold_timer

// *** core/grace_timer.sv ***
// Grace interval timer for a write cycle still open when reset asserts.
// Assumes start is a one-cycle pulse at reset assertion.
`timescale 1ns/10ps
`include "supply_supervisor_cfg.svh"
module grace_timer (
    // Clock and reset
    input  wire logic clock,
    input  wire logic srst,
    // Control
    input  wire logic start,
    // Status
    output logic      expired
);
    logic [`GRACE_W-1:0] count_q;

    assign expired = (count_q >= `GRACE_W'(`GRACE_CYCLES - 1));

    // Count the grace interval after each start
    always_ff @(posedge clock) begin
        if (srst || start) begin
            count_q <= `GRACE_ZERO;
        end else if (!expired) begin
            count_q <= count_q + `GRACE_W'(1);
        end
    end
endmodule : grace_timer

// *** core/supply_supervisor_gating.sv ***
// Control logic of a processor supply supervisor: chip-select gating,
// fail and early-warning flags, RAM rail switchover and backup states.
// Assumes comparator decisions arrive as levels synchronous to clock.
//
// Behaviour
// - While reset is asserted, pass gate off and chip-select input high-impedance, except in grace after first half.
// - Chip-select input high at reset assertion: gate off at once.
// - Chip-select input low at reset: grace until it rises or 10 us, gate still off in first half.
// - Gate held off during first half of hold period on every reset.
// - Pull chip-select output to RAM rail while gate off, release when on.
// - Early warning high above its level, low below it.
// - When enabled, fail flag low while monitor input below compare level.
// - Below switchover level, fail comparator off and fail flag low.
// - Fail flag forced high during first half of hold period, when above switchover level.
// - From second half of hold period, fail flag tracks the comparator.
// - Reset held while manual reset low and 200 ms after release.
// - Backup when supply below switchover and cell above supply, or below 1.75 V.
// - Leave backup past cell if cell below reset level, else at reset level.
// - RAM rail back on main supply at reset level, or past the cell if cell below reset level.
// - Backup-active high exactly while RAM rail on the cell.
// - Backup mode forces status outputs low and disables inputs.
// - Outside reset the pass gate is on and passes every transition.
// - Reset held for the hold period after supply rises above reset level.
// - Supply below reset level asserts reset and restarts the hold timer.
`timescale 1ns/10ps
`include "supply_supervisor_cfg.svh"
module supply_supervisor_gating #(
    parameter logic [`CNT_W-1:0] HOLD_CYCLES = `CNT_W'(`HOLD_CYCLES_DEF)
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic srst,
    // Comparator decisions, high when true
    input  wire logic supplyAboveReset,
    input  wire logic supplyAboveWarn,
    input  wire logic supplyAboveSwitch,
    input  wire logic supplyAbove175,
    input  wire logic cellAboveSupply,
    input  wire logic cellAboveReset,
    input  wire logic monitorAboveFail,
    // Processor side inputs
    input  wire logic manual_reset_n,
    input  wire logic chipSelectInLevel,
    input  wire logic watchdogFaultIn_n,
    input  wire logic cellHealthIn,
    // Reset outputs
    output logic      reset_n,
    output logic      resetHigh,
    // Chip-select gate controls
    output logic      passGateOn,
    output logic      chipSelectInHiZ,
    output logic      pullUpOn,
    output logic      pullToCell,
    // Status flags
    output logic      early_warning_n,
    output logic      supply_fail_flag_n,
    output logic      watchdog_fault_n,
    output logic      cell_health,
    // Rail control
    output logic      backup_active,
    output logic      monitorEnable,
    output logic      kickEnable,
    output logic      manualEnable
);
    logic        backup_q;
    logic        backup_d;
    logic        inReset;
    logic        holdRunning;
    logic        holdFirstHalf;
    logic        resetPrev_q;
    logic        resetRise;
    logic        graceExpired;
    logic        gateOn_d;
    logic        enterBackup;
    logic        leaveBackup;
    logic        holdRestart;
    supply_supervisor_pkg::gate_state_t gate_q;
    supply_supervisor_pkg::gate_state_t gate_d;

    logic reset_n_q, resetHigh_q, passGateOn_q, chipSelectInHiZ_q, pullUpOn_q;
    logic pullToCell_q, early_warning_n_q, supply_fail_flag_n_q;
    logic watchdog_fault_n_q, cell_health_q, monitorEnable_q;
    logic kickEnable_q, manualEnable_q;

    // Backup entry and exit decisions
    assign enterBackup = (!supplyAboveSwitch && cellAboveSupply) || !supplyAbove175;
    assign leaveBackup = cellAboveReset ? supplyAboveReset
                                        : (!cellAboveSupply && supplyAbove175);
    assign backup_d    = backup_q ? !leaveBackup : enterBackup;

    // Hold restart while supply low or manual reset held; inputs off in backup
    assign holdRestart = !supplyAboveReset
                         || (!manual_reset_n && !backup_q);
    assign inReset     = holdRunning || backup_q;
    assign resetRise   = inReset && !resetPrev_q;

    hold_timer #(
        .HOLD_CYCLES (HOLD_CYCLES)
    ) u_hold (
        .clock     (clock),
        .srst      (srst),
        .restart   (holdRestart),
        .running   (holdRunning),
        .firstHalf (holdFirstHalf)
    );

    grace_timer u_grace (
        .clock   (clock),
        .srst    (srst),
        .start   (resetRise),
        .expired (graceExpired)
    );

    // Gate state: grace only if chip select was low when reset asserted
    always_comb begin
        gate_d = gate_q;
        case (gate_q)
            supply_supervisor_pkg::GATE_PASS: begin
                if (resetRise && !chipSelectInLevel && !backup_q) begin
                    gate_d = supply_supervisor_pkg::GATE_GRACE;
                end else if (resetRise) begin
                    gate_d = supply_supervisor_pkg::GATE_BLOCK;
                end
            end
            supply_supervisor_pkg::GATE_GRACE: begin
                if (!inReset) begin
                    gate_d = supply_supervisor_pkg::GATE_PASS;
                end else if (chipSelectInLevel || graceExpired || backup_q) begin
                    gate_d = supply_supervisor_pkg::GATE_BLOCK;
                end
            end
            default: begin
                if (!inReset) begin
                    gate_d = supply_supervisor_pkg::GATE_PASS;
                end
            end
        endcase
    end

    // Gate on outside reset or within grace; first half always blocks
    assign gateOn_d = (gate_d == supply_supervisor_pkg::GATE_PASS && !inReset)
                      || (gate_d == supply_supervisor_pkg::GATE_GRACE
                          && !holdFirstHalf);

    // Gate state register
    always_ff @(posedge clock) begin
        if (srst) begin
            gate_q      <= supply_supervisor_pkg::GATE_BLOCK;
            backup_q    <= 1'b0;
            resetPrev_q <= 1'b1;
        end else begin
            gate_q      <= gate_d;
            backup_q    <= backup_d;
            resetPrev_q <= inReset;
        end
    end

    // Reset and gate outputs
    always_ff @(posedge clock) begin
        if (srst) begin
            reset_n_q         <= 1'b0;
            resetHigh_q       <= 1'b1;
            passGateOn_q      <= 1'b0;
            chipSelectInHiZ_q <= 1'b1;
            pullUpOn_q        <= 1'b1;
            pullToCell_q      <= 1'b0;
        end else begin
            reset_n_q         <= !inReset;
            resetHigh_q       <= inReset && !backup_d;
            passGateOn_q      <= gateOn_d && !backup_d;
            chipSelectInHiZ_q <= !gateOn_d || backup_d;
            pullUpOn_q        <= !gateOn_d || backup_d;
            pullToCell_q      <= backup_d;
        end
    end

    // Status flag outputs
    always_ff @(posedge clock) begin
        if (srst) begin
            early_warning_n_q    <= 1'b0;
            supply_fail_flag_n_q <= 1'b1;
            watchdog_fault_n_q   <= 1'b1;
            cell_health_q        <= 1'b0;
            monitorEnable_q      <= 1'b0;
            kickEnable_q         <= 1'b0;
            manualEnable_q       <= 1'b0;
            backup_active        <= 1'b0;
        end else begin
            early_warning_n_q <= supplyAboveWarn && !backup_d;
            if (backup_d || !supplyAboveSwitch) begin
                supply_fail_flag_n_q <= 1'b0;
            end else if (holdRunning && holdFirstHalf) begin
                supply_fail_flag_n_q <= 1'b1;
            end else begin
                supply_fail_flag_n_q <= monitorAboveFail;
            end
            watchdog_fault_n_q <= watchdogFaultIn_n && !backup_d;
            cell_health_q      <= cellHealthIn && !backup_d;
            monitorEnable_q    <= supplyAboveSwitch && !backup_d
                                  && !(holdRunning && holdFirstHalf);
            kickEnable_q       <= !backup_d;
            manualEnable_q     <= !backup_d;
            backup_active      <= backup_d;
        end
    end

    // Registered outputs
    assign reset_n            = reset_n_q;
    assign resetHigh          = resetHigh_q;
    assign passGateOn         = passGateOn_q;
    assign chipSelectInHiZ    = chipSelectInHiZ_q;
    assign pullUpOn           = pullUpOn_q;
    assign pullToCell         = pullToCell_q;
    assign early_warning_n    = early_warning_n_q;
    assign supply_fail_flag_n = supply_fail_flag_n_q;
    assign watchdog_fault_n   = watchdog_fault_n_q;
    assign cell_health        = cell_health_q;
    assign monitorEnable      = monitorEnable_q;
    assign kickEnable         = kickEnable_q;
    assign manualEnable       = manualEnable_q;
endmodule : supply_supervisor_gating

// *** tb/supply_supervisor_gating_asserts.sv ***
// Port checker of the supply supervisor gating block.
// Assumes it is bound to the top module and comparator levels stay consistent.
`timescale 1ns/10ps
module supply_supervisor_gating_asserts #(
    parameter logic [23:0] HOLD_CYCLES = 24'h000014
) (
    // Clock, reset and inputs
    input wire logic clock,
    input wire logic srst,
    input wire logic supplyAboveReset,
    input wire logic supplyAboveWarn,
    input wire logic supplyAboveSwitch,
    input wire logic supplyAbove175,
    input wire logic monitorAboveFail,
    input wire logic manual_reset_n,
    // Outputs watched
    input wire logic reset_n,
    input wire logic passGateOn,
    input wire logic chipSelectInHiZ,
    input wire logic pullUpOn,
    input wire logic early_warning_n,
    input wire logic supply_fail_flag_n,
    input wire logic backup_active
);
    logic [23:0] okCount_q;
    wire         okCond;
    // Cycles since the reset cause went away
    assign okCond = supplyAboveReset && manual_reset_n;
    always_ff @(posedge clock) begin
        if (srst || !okCond) okCount_q <= 24'h000000;
        else if (okCount_q != 24'hFFFFFF) okCount_q <= okCount_q + 24'h000001;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    a_gate_follows_run: assert property (passGateOn == reset_n && chipSelectInHiZ == !passGateOn)
        else $error("gate state disagrees with reset");
    a_pull_up_gate: assert property (passGateOn ? !pullUpOn : (backup_active || pullUpOn))
        else $error("pull-up state wrong");
    a_warn_high: assert property (supplyAboveWarn && supplyAboveReset |=> early_warning_n)
        else $error("early warning low above level");
    a_warn_low: assert property (!supplyAboveWarn |=> !early_warning_n)
        else $error("early warning high below level");
    a_fail_below_sw: assert property (!supplyAboveSwitch |=> !supply_fail_flag_n)
        else $error("fail flag high below switchover");
    a_fail_tracks: assert property (reset_n && okCond |=> supply_fail_flag_n == $past(monitorAboveFail))
        else $error("fail flag does not track monitor");
    a_hold_wait: assert property (okCount_q != 24'h000000 && okCount_q < HOLD_CYCLES |-> !reset_n)
        else $error("reset released early");
    a_hold_release: assert property (okCount_q == HOLD_CYCLES + 24'h000003 |-> reset_n)
        else $error("reset released late");
    a_backup_enter: assert property (!supplyAbove175 |=> backup_active)
        else $error("no backup below low level");
    a_backup_exit: assert property (supplyAboveReset |=> !backup_active)
        else $error("backup kept above reset level");
    a_backup_states: assert property (backup_active |-> !reset_n && !early_warning_n && !supply_fail_flag_n)
        else $error("backup output states wrong");
endmodule : supply_supervisor_gating_asserts

// *** tb/cpu_write_model.sv ***
// Processor model: runs write cycles on the active-low chip-select input.
// Assumes the bench raises busy to start writes; idle level is high.
`timescale 1ns/10ps
module cpu_write_model (
    // Clock and control
    input wire logic clock,
    input wire logic busy,
    // Chip select towards the block
    output logic     chipSelectInLevel
);
    logic [1:0] phase_q;
    initial phase_q = 2'h0;
    initial chipSelectInLevel = 1'b1;
    // Low two cycles of every four while busy
    always @(posedge clock) begin
        phase_q <= phase_q + 2'h1;
        chipSelectInLevel <= !(busy && phase_q[1]);
    end
endmodule : cpu_write_model

// *** tb/tb_supply_supervisor_gating.sv ***
// Testbench of the supply supervisor gating block with a processor model.
// Assumes a 10 MHz clock and a hold period shortened to 20 cycles.
`timescale 1ns/10ps
module tb_supply_supervisor_gating;
    localparam logic [23:0] HOLD = 24'h000014;
    logic clock, srst, aRst, aWarn, aSw, a175, cellSup, cellRst, monOk;
    logic manual_reset_n, wdIn_n, cellIn, busy, csIn, reset_n, passGateOn, hiZ, pullUpOn;
    logic early_warning_n, supply_fail_flag_n, backup_active, manualEnable;
    logic resetHigh, pullToCell, wdOut_n, cellOut, monEn, kickEn;
    int   err_total = 0;
    int   checks = 0;
    supply_supervisor_gating #(.HOLD_CYCLES(HOLD)) u_dut (
        .clock(clock), .srst(srst), .supplyAboveReset(aRst), .supplyAboveWarn(aWarn),
        .supplyAboveSwitch(aSw), .supplyAbove175(a175), .cellAboveSupply(cellSup),
        .cellAboveReset(cellRst), .monitorAboveFail(monOk), .manual_reset_n(manual_reset_n),
        .chipSelectInLevel(csIn), .watchdogFaultIn_n(wdIn_n), .cellHealthIn(cellIn),
        .reset_n(reset_n), .resetHigh(resetHigh), .passGateOn(passGateOn),
        .chipSelectInHiZ(hiZ), .pullUpOn(pullUpOn), .pullToCell(pullToCell),
        .early_warning_n(early_warning_n), .supply_fail_flag_n(supply_fail_flag_n),
        .watchdog_fault_n(wdOut_n), .cell_health(cellOut),
        .backup_active(backup_active), .monitorEnable(monEn), .kickEnable(kickEn),
        .manualEnable(manualEnable));
    cpu_write_model u_cpu (.clock(clock), .busy(busy), .chipSelectInLevel(csIn));
    task automatic chk(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc
    // Supply levels: reset, warning, switchover, low-level comparators
    task automatic supply(input logic [3:0] lv);
        @(posedge clock);
        {aRst, aWarn, aSw, a175} <= lv;
    endtask : supply
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : complete_run
    // Power-up with writes running and the monitor input low
    task automatic t_powerup();
        @(posedge clock);
        monOk <= 1'b0;
        busy <= 1'b1;
        supply(4'hF);
        cyc(8);
        chk(passGateOn, 1'b0);
        chk(supply_fail_flag_n, 1'b1);
        chk(monEn, 1'b0);
        chk(resetHigh, 1'b1);
        cyc(10);
        chk(reset_n, 1'b0);
        chk(supply_fail_flag_n, 1'b0);
        cyc(6);
        chk(reset_n, 1'b1);
        chk(passGateOn, 1'b1);
        chk(pullUpOn, 1'b0);
        chk(resetHigh, 1'b0);
        chk(monEn, 1'b1);
        chk(wdOut_n, 1'b1);
        chk(cellOut, 1'b1);
        chk(kickEn, 1'b1);
        @(posedge clock);
        monOk <= 1'b1;
        cyc(2);
        chk(supply_fail_flag_n, 1'b1);
        $display("powerup done");
    endtask : t_powerup
    // Early warning, then a brownout during writes
    task automatic t_brownout();
        supply(4'hB);
        cyc(2);
        chk(early_warning_n, 1'b0);
        chk(reset_n, 1'b1);
        supply(4'h3);
        cyc(2);
        chk(reset_n, 1'b0);
        chk(passGateOn, 1'b0);
        chk(pullUpOn, 1'b1);
        supply(4'hF);
        cyc(24);
        chk(reset_n, 1'b1);
        chk(early_warning_n, 1'b1);
        $display("brownout done");
    endtask : t_brownout
    // Manual reset held, then released
    task automatic t_manual();
        @(posedge clock);
        manual_reset_n <= 1'b0;
        cyc(30);
        chk(reset_n, 1'b0);
        @(posedge clock);
        manual_reset_n <= 1'b1;
        cyc(18);
        chk(reset_n, 1'b0);
        cyc(6);
        chk(reset_n, 1'b1);
        $display("manual done");
    endtask : t_manual
    // Backup entry and exit with the cell above reset level
    task automatic t_backup();
        @(posedge clock);
        cellSup <= 1'b1;
        cellRst <= 1'b1;
        supply(4'h1);
        cyc(2);
        chk(backup_active, 1'b1);
        chk(supply_fail_flag_n, 1'b0);
        chk(early_warning_n, 1'b0);
        chk(manualEnable, 1'b0);
        chk(hiZ, 1'b1);
        chk(pullToCell, 1'b1);
        chk(wdOut_n, 1'b0);
        chk(cellOut, 1'b0);
        chk(kickEn, 1'b0);
        chk(monEn, 1'b0);
        chk(resetHigh, 1'b0);
        chk(reset_n, 1'b0);
        supply(4'h0);
        cyc(2);
        chk(backup_active, 1'b1);
        supply(4'h3);
        cyc(2);
        chk(backup_active, 1'b1);
        supply(4'hF);
        cyc(2);
        chk(backup_active, 1'b0);
        chk(pullToCell, 1'b0);
        cyc(24);
        chk(reset_n, 1'b1);
        $display("backup done");
    endtask : t_backup
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    initial begin
        #300000;
        err_total++;
        complete_run();
    end
    initial begin
        srst = 1'b1;
        {aRst, aWarn, aSw, a175} = 4'h3;
        {cellSup, cellRst, monOk, busy} = 4'h0;
        {manual_reset_n, wdIn_n, cellIn} = 3'h7;
        repeat (4) @(posedge clock);
        srst <= 1'b0;
        cyc(1);
        chk(reset_n, 1'b0);
        chk(hiZ, 1'b1);
        chk(pullUpOn, 1'b1);
        t_powerup();
        t_brownout();
        t_manual();
        t_backup();
        complete_run();
    end
endmodule : tb_supply_supervisor_gating
bind supply_supervisor_gating supply_supervisor_gating_asserts #(.HOLD_CYCLES(HOLD_CYCLES)) u_chk (
    .clock(clock), .srst(srst), .supplyAboveReset(supplyAboveReset),
    .supplyAboveWarn(supplyAboveWarn), .supplyAboveSwitch(supplyAboveSwitch),
    .supplyAbove175(supplyAbove175), .monitorAboveFail(monitorAboveFail),
    .manual_reset_n(manual_reset_n), .reset_n(reset_n), .passGateOn(passGateOn),
    .chipSelectInHiZ(chipSelectInHiZ), .pullUpOn(pullUpOn), .early_warning_n(early_warning_n),
    .supply_fail_flag_n(supply_fail_flag_n), .backup_active(backup_active));
